// ===== verif/serial_port_pin_override_mux_tb_top.sv
// serial_port_pin_override_mux_tb_top: table-driven and directed checks of the pin mux
// assumes sppm_properties bound in its own file
`timescale 1ns/1ps
`default_nettype none
module serial_port_pin_override_mux_tb_top;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, ser_rx_data, ser_clk_in;
	logic ser_tx_data = 1'h1, ser_clk_out = 1'h1;
	logic [2:0] pin_in = 3'h0, pin_out, pin_oe, pin_pd_en;
	int n_fail = 0, check_count = 0;
	// latch dir inhib ctrl gpd pin | oe out pd read
	logic [26:0] rows [6] = '{
		{3'h5, 3'h0, 3'h0, 2'h0, 1'h0, 3'h6, 3'h0, 3'h5, 3'h7, 3'h6},
		{3'h5, 3'h0, 3'h2, 2'h0, 1'h0, 3'h3, 3'h0, 3'h5, 3'h5, 3'h3},
		{3'h5, 3'h0, 3'h0, 2'h0, 1'h1, 3'h2, 3'h0, 3'h5, 3'h0, 3'h2},
		{3'h5, 3'h7, 3'h0, 2'h0, 1'h0, 3'h2, 3'h7, 3'h5, 3'h0, 3'h5},
		{3'h2, 3'h3, 3'h0, 2'h1, 1'h0, 3'h5, 3'h1, 3'h5, 3'h0, 3'h6},
		{3'h5, 3'h4, 3'h0, 2'h3, 1'h0, 3'h3, 3'h5, 3'h5, 3'h0, 3'h7}};
	sppm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pd_en(pin_pd_en), .ser_tx_data(ser_tx_data), .ser_clk_out(ser_clk_out),
		.ser_rx_data(ser_rx_data), .ser_clk_in(ser_clk_in));
	always #5 pclk = ~pclk;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t got %0h expected %0h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// only the watchdog ends a stalled access
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		print_verdict;
	end
	initial begin
		logic [2:0] l, d, h, p, eo, et, ep, er;
		logic [1:0] c;
		logic g;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		chk(pin_pd_en, 3'h7);
		chk(pin_oe, 3'h0);
		foreach (rows[i]) begin
			{l, d, h, c, g, p, eo, et, ep, er} = rows[i];
			apb(1'h1, 8'h00, l);
			apb(1'h1, 8'h04, d);
			apb(1'h1, 8'h08, h);
			apb(1'h1, 8'h10, g);
			apb(1'h1, 8'h0C, c);
			pin_in <= p;
			apb(1'h0, 8'h00, 32'h0);
			chk(pin_oe, eo);
			chk(pin_out, et);
			chk(pin_pd_en, ep);
			chk(r, er);
		end
		// serial owns pins: cpu writes land in the data and dir registers only
		apb(1'h1, 8'h00, 32'h2);
		apb(1'h1, 8'h04, 32'h3);
		apb(1'h0, 8'h04, 32'h0);
		chk(r, 32'h3);
		chk(pin_oe, 3'h5);
		chk(pin_out, 3'h5);
		apb(1'h0, 8'h00, 32'h0);
		chk(r, 32'h2);
		apb(1'h1, 8'h0C, 32'h0);
		apb(1'h0, 8'h14, 32'h0);
		chk(r, 32'h3);
		chk(pin_oe, 3'h3);
		chk(pin_out, 3'h2);
		chk(pin_pd_en, 3'h4);
		apb(1'h1, 8'h18, 32'hF);
		chk(e, 1'h1);
		apb(1'h0, 8'h18, 32'h0);
		chk(r, 32'h0);
		chk(e, 1'h1);
		// serial master: pins follow the serial unit, not the latch
		apb(1'h1, 8'h0C, 32'h3);
		apb(1'h1, 8'h00, 32'h7);
		ser_tx_data <= 1'h0;
		ser_clk_out <= 1'h0;
		pin_in <= 3'h6;
		@(posedge pclk);
		chk(pin_out, 3'h0);
		chk(pin_oe, 3'h5);
		chk(pin_pd_en, 3'h0);
		chk({ser_clk_in, ser_rx_data}, 2'h3);
		// serial slave: clock pin released, external clock routed in
		apb(1'h1, 8'h0C, 32'h1);
		pin_in <= 3'h2;
		apb(1'h0, 8'h00, 32'h0);
		chk(pin_oe, 3'h1);
		chk({ser_clk_in, ser_rx_data}, 2'h1);
		chk(r, 32'h3);
		chk(pin_pd_en, 3'h0);
		// mid-run reset returns every register to its reset value
		@(posedge pclk);
		presetn <= 1'h0;
		@(posedge pclk);
		chk(pin_oe, 3'h0);
		chk(pin_pd_en, 3'h7);
		chk(pin_out, 3'h0);
		@(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 8'h04, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, 8'h0C, 32'h0);
		chk(r, 32'h0);
		chk(pin_pd_en, 3'h7);
		print_verdict;
	end
endmodule // serial_port_pin_override_mux_tb_top
`default_nettype wire

// ===== verif/sppm_properties.sv
// sppm_properties: port-level checks of the shared pin mux
// assumes binding to sppm_top, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module sppm_properties (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic [2:0]	pin_in,
	input wire logic [2:0]	pin_out,
	input wire logic [2:0]	pin_oe,
	input wire logic [2:0]	pin_pd_en,
	input wire logic	ser_tx_data,
	input wire logic	ser_clk_out,
	input wire logic	ser_rx_data,
	input wire logic	ser_clk_in
);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ser_on = psel & penable & pwrite & (paddr == 8'h0C) & pwdata[0];
	pd_drive_a: assert property ((pin_pd_en & pin_oe) == 3'h0)
		else $error("pulldown on a driven pin");
	rx_route_a: assert property (ser_rx_data == pin_in[1])
		else $error("receive data not from pin");
	clk_route_a: assert property (ser_clk_in == pin_in[2])
		else $error("clock input not from pin");
	ser_dir_a: assert property (ser_on |=> pin_oe == {$past(pwdata[1]), 2'h1})
		else $error("serial takeover direction wrong");
	ser_drive_a: assert property (ser_on |=> pin_out[0] == ser_tx_data && pin_pd_en == 3'h0)
		else $error("serial drive or pulldown wrong");
	reset_pd_a: assert property ($rose(presetn) |-> pin_pd_en == 3'h7 && pin_oe == 3'h0)
		else $error("pins not inputs with pulldown after reset");
	unmapped_access_a: assert property (psel && penable && paddr > 8'h14
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	rd_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside setup");
endmodule // sppm_properties
bind sppm_top sppm_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pd_en(pin_pd_en), .ser_tx_data(ser_tx_data), .ser_clk_out(ser_clk_out),
	.ser_rx_data(ser_rx_data), .ser_clk_in(ser_clk_in));
`default_nettype wire

// ===== verilog/sppm_ctl_if.sv
// sppm_ctl_if: control bits from the register file to the pin mux
// assumes both ends in the pclk domain
`timescale 1ns/1ps
`default_nettype none
interface sppm_ctl_if;
	logic [2:0] data_latch;
	logic [2:0] dir;
	logic [2:0] pd_inhibit;
	logic       serial_enable;
	logic       master_select;
	logic       global_pulldown_disable;
	logic [2:0] pin_read;
	modport regs (output data_latch, dir, pd_inhibit, serial_enable, master_select,
		global_pulldown_disable, input pin_read);
	modport mux (input data_latch, dir, pd_inhibit, serial_enable, master_select,
		global_pulldown_disable, output pin_read);
endinterface
`default_nettype wire

// ===== verilog/sppm_pin_mux.sv
// sppm_pin_mux: combinational steering of three shared pins
// assumes pin inputs synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module sppm_pin_mux
	import sppm_pkg::*;
(
	sppm_ctl_if.mux   ctl,
	input  wire logic [2:0] pin_in,
	output logic      [2:0] pin_out,
	output logic      [2:0] pin_oe,
	output logic      [2:0] pin_pd_en,
	input  wire logic       ser_tx_data,
	input  wire logic       ser_clk_out,
	output logic            ser_rx_data,
	output logic            ser_clk_in
);
	logic [2:0] ser_oe;
	logic [2:0] ser_out;

	always_comb begin
		ser_oe                = '0;
		ser_out               = '0;
		ser_oe[SPPM_PIN_SDO]  = 1'b1;
		ser_out[SPPM_PIN_SDO] = ser_tx_data;
		ser_oe[SPPM_PIN_SDI]  = 1'b0;
		ser_oe[SPPM_PIN_SCK]  = ctl.master_select;
		ser_out[SPPM_PIN_SCK] = ser_clk_out;
	end

	always_comb begin
		for (int i = 0; i < SPPM_NPINS; i++) begin
			if (ctl.serial_enable) begin
				pin_oe[i]  = ser_oe[i];
				pin_out[i] = ser_out[i];
			end else begin
				pin_oe[i]  = ctl.dir[i];
				pin_out[i] = ctl.data_latch[i];
			end
			// pulldown only for an unowned input pin
			pin_pd_en[i] = ~ctl.serial_enable & ~ctl.dir[i] & ~ctl.pd_inhibit[i]
				& ~ctl.global_pulldown_disable;
			// read: pin when input, latch when output
			ctl.pin_read[i] = ctl.dir[i] ? ctl.data_latch[i] : pin_in[i];
		end
	end

	assign ser_rx_data = pin_in[SPPM_PIN_SDI];
	assign ser_clk_in  = pin_in[SPPM_PIN_SCK];

endmodule // sppm_pin_mux
`default_nettype wire

// ===== verilog/sppm_pkg.sv
// sppm_pkg: register map, field positions and reset values of the shared pin mux
// assumes a 32-bit apb slave with word-aligned registers
package sppm_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] SPPM_ADDR_PORT_DATA = 8'h00;
	localparam logic [7:0] SPPM_ADDR_PORT_DIR  = 8'h04;
	localparam logic [7:0] SPPM_ADDR_PD_INHIB  = 8'h08;
	localparam logic [7:0] SPPM_ADDR_SER_CTRL  = 8'h0C;
	localparam logic [7:0] SPPM_ADDR_OPTION    = 8'h10;
	localparam logic [7:0] SPPM_ADDR_PIN_STAT  = 8'h14;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SPPM_PIN_SDO      = 0;
	localparam int SPPM_PIN_SDI      = 1;
	localparam int SPPM_PIN_SCK      = 2;
	localparam int SPPM_BIT_SER_EN   = 0;
	localparam int SPPM_BIT_MASTER   = 1;
	localparam int SPPM_BIT_GPD_DIS  = 0;
	localparam int SPPM_NPINS        = 3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0] SPPM_RST_DATA  = 3'h0;
	localparam logic [2:0] SPPM_RST_DIR   = 3'h0;
	localparam logic [2:0] SPPM_RST_INHIB = 3'h0;
	localparam logic [1:0] SPPM_RST_CTRL  = 2'h0;
	localparam logic       SPPM_RST_GPD   = 1'h0;

	typedef enum logic [1:0] {
		SPPM_IDLE   = 2'b01,
		SPPM_ACCESS = 2'b10
	} sppm_apb_state_t;

endpackage

// ===== verilog/sppm_top.sv
// sppm_top: apb register file and shared pin override for the serial unit
// assumes apb master in pclk domain; pins sampled synchronously
`timescale 1ns/1ps
`default_nettype none
module sppm_top
	import sppm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  pin_in,
	output logic      [2:0]  pin_out,
	output logic      [2:0]  pin_oe,
	output logic      [2:0]  pin_pd_en,
	input  wire logic        ser_tx_data,
	input  wire logic        ser_clk_out,
	output logic             ser_rx_data,
	output logic             ser_clk_in
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [2:0] data_ff;
	logic [2:0] dir_ff;
	logic [2:0] inhib_ff;
	logic [1:0] ctrl_ff;
	logic       gpd_ff;
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;
	logic [31:0] nxt_prdata;

	sppm_ctl_if ctl ();

	assign ctl.data_latch              = data_ff;
	assign ctl.dir                     = dir_ff;
	assign ctl.pd_inhibit              = inhib_ff;
	assign ctl.serial_enable           = ctrl_ff[SPPM_BIT_SER_EN];
	assign ctl.master_select           = ctrl_ff[SPPM_BIT_MASTER];
	assign ctl.global_pulldown_disable = gpd_ff;

	// ------------------------------------------------------------
	// apb decode: zero wait states, unmapped address errors
	// ------------------------------------------------------------
	always_comb begin
		unique case (paddr)
			SPPM_ADDR_PORT_DATA, SPPM_ADDR_PORT_DIR, SPPM_ADDR_PD_INHIB,
			SPPM_ADDR_SER_CTRL, SPPM_ADDR_OPTION, SPPM_ADDR_PIN_STAT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign rd_en   = psel & ~penable & ~pwrite;

	// data latch, written regardless of direction or ownership
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_ff <= SPPM_RST_DATA;
		end else if (wr_en && paddr == SPPM_ADDR_PORT_DATA) begin
			data_ff <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_ff <= SPPM_RST_DIR;
		end else if (wr_en && paddr == SPPM_ADDR_PORT_DIR) begin
			dir_ff <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inhib_ff <= SPPM_RST_INHIB;
		end else if (wr_en && paddr == SPPM_ADDR_PD_INHIB) begin
			inhib_ff <= pwdata[2:0];
		end
	end

	// serial takeover never touches data, dir or inhibit bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= SPPM_RST_CTRL;
		end else if (wr_en && paddr == SPPM_ADDR_SER_CTRL) begin
			ctrl_ff <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpd_ff <= SPPM_RST_GPD;
		end else if (wr_en && paddr == SPPM_ADDR_OPTION) begin
			gpd_ff <= pwdata[SPPM_BIT_GPD_DIS];
		end
	end

	// ------------------------------------------------------------
	// read data captured in setup phase
	// ------------------------------------------------------------
	always_comb begin
		nxt_prdata = '0;
		unique case (paddr)
			SPPM_ADDR_PORT_DATA: nxt_prdata[2:0] = ctl.pin_read;
			SPPM_ADDR_PORT_DIR:  nxt_prdata[2:0] = dir_ff;
			SPPM_ADDR_PD_INHIB:  nxt_prdata[2:0] = inhib_ff;
			SPPM_ADDR_SER_CTRL:  nxt_prdata[1:0] = ctrl_ff;
			SPPM_ADDR_OPTION:    nxt_prdata[0]   = gpd_ff;
			SPPM_ADDR_PIN_STAT:  nxt_prdata[2:0] = pin_in;
			default:             nxt_prdata      = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= nxt_prdata;
		end
	end

	// ------------------------------------------------------------
	// pin steering
	// ------------------------------------------------------------
	sppm_pin_mux u_mux (
		.ctl         (ctl.mux),
		.pin_in      (pin_in),
		.pin_out     (pin_out),
		.pin_oe      (pin_oe),
		.pin_pd_en   (pin_pd_en),
		.ser_tx_data (ser_tx_data),
		.ser_clk_out (ser_clk_out),
		.ser_rx_data (ser_rx_data),
		.ser_clk_in  (ser_clk_in)
	);

endmodule // sppm_top
`default_nettype wire
